// File: hw/region_protection_cfg.svh
// offsets, field positions, reset values and masks of the region protection block
// assumes a 32-bit apb data path with byte addresses on the low address bits
`ifndef REGION_PROTECTION_CFG_SVH
`define REGION_PROTECTION_CFG_SVH

`define ADDR_BITS        8
`define OFS_SELECT       8'h00
`define OFS_BASE         8'h04
`define OFS_ATTR         8'h08
`define OFS_CHECK_CTRL   8'h0c
`define OFS_FAULT_STAT   8'h10
`define OFS_FAULT_ADDR   8'h14

`define BASE_VALID_BIT   4
`define BASE_ADDR_LSB    5
`define ATTR_NO_EXEC     28
`define ATTR_PERM_LSB    24
`define ATTR_SHARE       18
`define ATTR_CACHE       17
`define ATTR_BUFFER      16
`define ATTR_SRD_LSB     8
`define ATTR_SIZE_LSB    1
`define ATTR_ENABLE      0
`define ATTR_RW_MASK     32'h1707ff3f

`define SELECT_RESET     3'h0
`define CTRL_RESET       1'h0
`define STAT_W1C_BIT     0

`endif

// File: hw/region_protection_pkg.sv
// types shared by the region protection block and its address matcher
// assumes nothing beyond the cfg header's field layout
package region_protection_pkg;

   typedef struct packed {
      logic [26:0] base;
      logic        no_exec_bit;
      logic [2:0]  permission_code;
      logic        shareable;
      logic        cacheable;
      logic        bufferable;
      logic [7:0]  subregion_disable_mask;
      logic [4:0]  size;
      logic        enable;
   } region_s;

   typedef enum logic [1:0] {
      MEM_STRONGLY_ORDERED,
      MEM_DEVICE,
      MEM_NORMAL_WT,
      MEM_NORMAL_WB
   } mem_type_e;

   // low address bits a region of this size spans; size 31 spans everything
   function automatic logic [31:0] size_mask(input logic [4:0] size);
      logic [5:0] lim;
      lim = {1'b0, size} + 6'd1;
      size_mask = (32'h1 << lim) - 32'h1;
   endfunction

endpackage

// File: hw/region_check_if.sv
// carrier between the register file and the address matcher
// assumes both ends run on the same clock; the matcher is purely combinational
`timescale 1ns/10ps
`default_nettype none
interface region_check_if;
   region_protection_pkg::region_s regions [8];
   logic [31:0]                    addr;
   logic                           write;
   logic                           fetch;
   logic                           priv;
   logic                           hit;
   logic [2:0]                     idx;
   logic                           permit;

   modport cfg (output regions, addr, write, fetch, priv, input hit, idx, permit);
   modport chk (input regions, addr, write, fetch, priv, output hit, idx, permit);
endinterface
`default_nettype wire

// File: hw/region_matcher.sv
// address match, subregion and permission evaluation over all eight regions
// assumes the region table and access fields are stable in the cycle they are sampled
`timescale 1ns/10ps
`default_nettype none
module region_matcher (
   // tables in, verdict out
   region_check_if.chk chk
);

   logic [7:0] match;

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_region
         logic [31:0] mask;
         logic [5:0]  shamt;
         logic [31:0] sub_word;
         logic        in_range;
         assign mask = region_protection_pkg::size_mask(chk.regions[g].size);
         // 4GB leaves no base bits, so the region covers the whole map
         assign in_range = ((chk.addr & ~mask) == ({chk.regions[g].base, 5'h00} & ~mask));
         // eight equal slices: the top three bits inside the span pick one
         assign shamt = (chk.regions[g].size > 5'h02) ? ({1'b0, chk.regions[g].size} - 6'd2)
                                                      : 6'd0;
         assign sub_word = chk.addr >> shamt;
         assign match[g] = chk.regions[g].enable & in_range
                         & ~chk.regions[g].subregion_disable_mask[sub_word[2:0]];
      end
   endgenerate

   // fetches are checked as reads
   function automatic logic allowed(input logic [2:0] code, input logic wr, input logic pv);
      case (code)
         3'h1:    allowed = pv;
         3'h2:    allowed = pv | ~wr;
         3'h3:    allowed = 1'b1;
         3'h5:    allowed = pv & ~wr;
         3'h6:    allowed = ~wr;
         3'h7:    allowed = ~wr;
         default: allowed = 1'b0;
      endcase
   endfunction

   // the last matching region wins, so walk upward
   always_comb begin
      chk.hit = 1'b0;
      chk.idx = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (match[i]) begin
            chk.hit = 1'b1;
            chk.idx = 3'(i);
         end
      end
   end

   always_comb begin
      chk.permit = chk.hit
                 & allowed(chk.regions[chk.idx].permission_code, chk.write, chk.priv)
                 & ~(chk.fetch & chk.regions[chk.idx].no_exec_bit);
   end

endmodule // region_matcher
`default_nettype wire

// File: hw/region_protection_config.sv
// region protection unit: eight region register sets behind apb and an access checker
// assumes the core presents one access per cycle on the same clock and takes the
// verdict one cycle later
`timescale 1ns/10ps
`default_nettype none
`include "region_protection_cfg.svh"
module region_protection_config (
   // clock and reset
   input  wire logic                  CLK,
   input  wire logic                  RST_B,
   // apb slave
   input  wire logic                  PSEL,
   input  wire logic                  PENABLE,
   input  wire logic                  PWRITE,
   input  wire logic [`ADDR_BITS-1:0] PADDR,
   input  wire logic [31:0]           PWDATA,
   output var  logic [31:0]           PRDATA,
   output var  logic                  PREADY,
   output var  logic                  PSLVERR,
   // access from the core
   input  wire logic                  ACC_VALID,
   input  wire logic [31:0]           ACC_ADDR,
   input  wire logic                  ACC_WRITE,
   input  wire logic                  ACC_FETCH,
   input  wire logic                  ACC_PRIV,
   // verdict, one cycle after the access
   output var  logic                  ACC_DONE,
   output var  logic                  ACC_HIT,
   output var  logic [2:0]            ACC_REGION,
   output var  logic [1:0]            ACC_MEM_TYPE,
   output var  logic                  ACC_SHAREABLE,
   output var  logic                  FATAL_FAULT
);

   region_check_if chk_if ();

   region_protection_pkg::region_s   regions_reg [8];
   logic [2:0]                       region_number_select_reg;
   logic                             check_enable_reg;
   logic                             fault_seen_reg;
   logic [2:0]                       fault_kind_reg;
   logic [31:0]                      fault_addr_reg;
   logic [31:0]                      prdata_reg;
   logic                             pready_reg;
   logic                             pslverr_reg;
   logic                             done_reg;
   logic                             hit_reg;
   logic [2:0]                       region_reg;
   region_protection_pkg::mem_type_e mem_type_reg;
   logic                             share_reg;
   logic                             fault_reg;

   logic                             setup;
   logic                             wr_commit;
   logic                             mapped;
   logic [31:0]                      rdata_next;
   logic [2:0]                       base_target;
   logic                             acc_fault;
   logic                             fault_clear;
   region_protection_pkg::region_s   sel_region;

   // apb decode
   assign setup     = PSEL & ~PENABLE & ~pready_reg;
   assign wr_commit = PSEL & PENABLE & pready_reg & PWRITE & mapped;

   always_comb begin
      case (PADDR)
         `OFS_SELECT:     mapped = 1'b1;
         `OFS_BASE:       mapped = 1'b1;
         `OFS_ATTR:       mapped = 1'b1;
         `OFS_CHECK_CTRL: mapped = 1'b1;
         `OFS_FAULT_STAT: mapped = 1'b1;
         `OFS_FAULT_ADDR: mapped = 1'b1;
         default:         mapped = 1'b0;
      endcase
   end

   // no wait state: ready is registered from the setup cycle, so read data and ready both leave flip-flops
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= setup;
      end
   end

   // unmapped offsets answer with an error and no data
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         pslverr_reg <= 1'b0;
      end else begin
         pslverr_reg <= setup & ~mapped;
      end
   end

   // data stands only in the access cycle, so a stale read never lingers on the bus
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         prdata_reg <= 32'h0;
      end else if (setup && !PWRITE && mapped) begin
         prdata_reg <= rdata_next;
      end else begin
         prdata_reg <= 32'h0;
      end
   end

   // region select and base targeting
   assign sel_region  = regions_reg[region_number_select_reg];
   assign base_target = PWDATA[`BASE_VALID_BIT] ? PWDATA[2:0]
                                                : region_number_select_reg;

   // only the low three bits are kept, so the select cannot leave 0..7
   // a select write and a base write with valid set both move it
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         region_number_select_reg <= `SELECT_RESET;
      end else if (wr_commit && PADDR == `OFS_SELECT) begin
         region_number_select_reg <= PWDATA[2:0];
      end else if (wr_commit && PADDR == `OFS_BASE && PWDATA[`BASE_VALID_BIT]) begin
         region_number_select_reg <= PWDATA[2:0];
      end
   end

   // region tables
   // each region keeps its own set; only the targeted one takes a write
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_table
         always_ff @(posedge CLK or negedge RST_B) begin
            if (!RST_B) begin
               regions_reg[g] <= '0;
            end else if (wr_commit && PADDR == `OFS_BASE && base_target == 3'(g)) begin
               // full base kept; bits under the region size are hidden on read
               regions_reg[g].base <= PWDATA[31:`BASE_ADDR_LSB];
            end else if (wr_commit && PADDR == `OFS_ATTR && region_number_select_reg == 3'(g)) begin
               regions_reg[g].no_exec_bit            <= PWDATA[`ATTR_NO_EXEC];
               regions_reg[g].permission_code        <= PWDATA[`ATTR_PERM_LSB +: 3];
               regions_reg[g].shareable              <= PWDATA[`ATTR_SHARE];
               regions_reg[g].cacheable              <= PWDATA[`ATTR_CACHE];
               regions_reg[g].bufferable             <= PWDATA[`ATTR_BUFFER];
               regions_reg[g].subregion_disable_mask <= PWDATA[`ATTR_SRD_LSB +: 8];
               regions_reg[g].size                   <= PWDATA[`ATTR_SIZE_LSB +: 5];
               regions_reg[g].enable                 <= PWDATA[`ATTR_ENABLE];
            end
         end
      end
   endgenerate

   // read mux
   always_comb begin
      rdata_next = 32'h0;
      case (PADDR)
         `OFS_SELECT: begin
            rdata_next[2:0] = region_number_select_reg;
         end
         `OFS_BASE: begin
            // valid reads zero; region field shows the select
            rdata_next = {sel_region.base, 5'h00}
                       & ~region_protection_pkg::size_mask(sel_region.size);
            rdata_next[2:0] = region_number_select_reg;
         end
         `OFS_ATTR: begin
            rdata_next[`ATTR_NO_EXEC]          = sel_region.no_exec_bit;
            rdata_next[`ATTR_PERM_LSB +: 3]    = sel_region.permission_code;
            rdata_next[`ATTR_SHARE]            = sel_region.shareable;
            rdata_next[`ATTR_CACHE]            = sel_region.cacheable;
            rdata_next[`ATTR_BUFFER]           = sel_region.bufferable;
            rdata_next[`ATTR_SRD_LSB +: 8]     = sel_region.subregion_disable_mask;
            rdata_next[`ATTR_SIZE_LSB +: 5]    = sel_region.size;
            rdata_next[`ATTR_ENABLE]           = sel_region.enable;
            rdata_next = rdata_next & `ATTR_RW_MASK;
         end
         `OFS_CHECK_CTRL: begin
            rdata_next[0] = check_enable_reg;
         end
         `OFS_FAULT_STAT: begin
            rdata_next[3:0] = {fault_kind_reg, fault_seen_reg};
         end
         `OFS_FAULT_ADDR: begin
            rdata_next = fault_addr_reg;
         end
         default: begin
            rdata_next = 32'h0;
         end
      endcase
   end

   // checking control
   // off after reset, so software can fill the table before faults start
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         check_enable_reg <= `CTRL_RESET;
      end else if (wr_commit && PADDR == `OFS_CHECK_CTRL) begin
         check_enable_reg <= PWDATA[0];
      end
   end

   // hand the table and the access to the matcher
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_feed
         assign chk_if.regions[g] = regions_reg[g];
      end
   endgenerate
   assign chk_if.addr  = ACC_ADDR;
   // a fetch is judged as a read, whatever the store flag says
   assign chk_if.write = ACC_WRITE & ~ACC_FETCH;
   assign chk_if.fetch = ACC_FETCH;
   assign chk_if.priv  = ACC_PRIV;

   region_matcher u_matcher (
      .chk (chk_if)
   );

   // no matching region or missing right fault alike; a disabled subregion counts as no match, so a lower region may still take the access
   assign acc_fault   = ACC_VALID & check_enable_reg & ~chk_if.permit;
   assign fault_clear = wr_commit && PADDR == `OFS_FAULT_STAT && PWDATA[`STAT_W1C_BIT];

   // sticky fault flag; a new fault beats a clear in the same cycle
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         fault_seen_reg <= 1'b0;
      end else if (acc_fault) begin
         fault_seen_reg <= 1'b1;
      end else if (fault_clear) begin
         fault_seen_reg <= 1'b0;
      end
   end

   // kind and address of the latest fault
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         fault_kind_reg <= 3'h0;
         fault_addr_reg <= 32'h0;
      end else if (acc_fault) begin
         fault_kind_reg <= {ACC_PRIV, ACC_FETCH, ACC_WRITE};
         fault_addr_reg <= ACC_ADDR;
      end
   end

   // verdict strobe, one cycle after every access
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= ACC_VALID;
      end
   end

   // fault strobe stands beside the verdict strobe
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         fault_reg <= 1'b0;
      end else begin
         fault_reg <= acc_fault;
      end
   end

   // no hit is reported while checking is off
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         hit_reg <= 1'b0;
      end else begin
         hit_reg <= ACC_VALID & check_enable_reg & chk_if.hit;
      end
   end

   // region reads zero between accesses
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         region_reg <= 3'h0;
      end else begin
         region_reg <= ACC_VALID ? chk_if.idx : 3'h0;
      end
   end

   // memory type of the winning region; it holds until the next access
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         mem_type_reg <= region_protection_pkg::MEM_STRONGLY_ORDERED;
      end else if (ACC_VALID && check_enable_reg && chk_if.hit) begin
         if (!regions_reg[chk_if.idx].cacheable) begin
            mem_type_reg <= regions_reg[chk_if.idx].bufferable
                          ? region_protection_pkg::MEM_DEVICE
                          : region_protection_pkg::MEM_STRONGLY_ORDERED;
         end else begin
            // normal memory, never write-allocate
            mem_type_reg <= regions_reg[chk_if.idx].bufferable
                          ? region_protection_pkg::MEM_NORMAL_WB
                          : region_protection_pkg::MEM_NORMAL_WT;
         end
      end else if (ACC_VALID) begin
         mem_type_reg <= region_protection_pkg::MEM_STRONGLY_ORDERED;
      end
   end

   // non-cacheable types are always shared, whatever the shareable bit says
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         share_reg <= 1'b1;
      end else if (ACC_VALID && check_enable_reg && chk_if.hit) begin
         share_reg <= ~regions_reg[chk_if.idx].cacheable | regions_reg[chk_if.idx].shareable;
      end else if (ACC_VALID) begin
         share_reg <= 1'b1;
      end
   end

   // outputs
   assign PRDATA        = prdata_reg;
   assign PREADY        = pready_reg;
   assign PSLVERR       = pslverr_reg;
   assign ACC_DONE      = done_reg;
   assign ACC_HIT       = hit_reg;
   assign ACC_REGION    = region_reg;
   assign ACC_MEM_TYPE  = mem_type_reg;
   assign ACC_SHAREABLE = share_reg;
   assign FATAL_FAULT   = fault_reg;

endmodule // region_protection_config
`default_nettype wire

// File: verif/region_protection_config_checker.sv
// concurrent checks on the ports of the region protection block
// assumes an apb master that holds address and direction through the access phase
`timescale 1ns/10ps
`default_nettype none
`include "region_protection_cfg.svh"
module region_protection_config_checker (
   // clock and reset
   input wire logic                  CLK,
   input wire logic                  RST_B,
   // apb
   input wire logic                  PSEL,
   input wire logic                  PENABLE,
   input wire logic                  PWRITE,
   input wire logic [`ADDR_BITS-1:0] PADDR,
   input wire logic [31:0]           PRDATA,
   input wire logic                  PREADY,
   input wire logic                  PSLVERR,
   // access and verdict
   input wire logic                  ACC_VALID,
   input wire logic                  ACC_DONE,
   input wire logic                  ACC_HIT,
   input wire logic [1:0]            ACC_MEM_TYPE,
   input wire logic                  ACC_SHAREABLE,
   input wire logic                  FATAL_FAULT
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   wire logic rd_ok = PREADY && !PWRITE && !PSLVERR;

   a_ready_setup: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("ready missing after setup");
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");
   a_done_access: assert property (ACC_VALID |=> ACC_DONE)
      else $error("no verdict after access");
   a_quiet_idle: assert property (!ACC_VALID |=> !ACC_DONE && !FATAL_FAULT)
      else $error("verdict without access");
   a_fault_done: assert property (FATAL_FAULT |-> ACC_DONE)
      else $error("fault outside verdict cycle");
   a_base_valid_zero: assert property (rd_ok && PADDR == `OFS_BASE |-> !PRDATA[4])
      else $error("base valid flag read as one");
   a_attr_reserved: assert property (rd_ok && PADDR == `OFS_ATTR
      |-> (PRDATA & ~`ATTR_RW_MASK) == 32'h0)
      else $error("reserved attribute bits read nonzero");
   a_select_range: assert property (rd_ok && PADDR == `OFS_SELECT
      |-> PRDATA[31:3] == 29'h0)
      else $error("region select out of range");
   a_error_quiet: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
      else $error("error response carries data");
   a_ordered_shared: assert property (ACC_MEM_TYPE < 2'h2 |-> ACC_SHAREABLE)
      else $error("device memory not shareable");

   cover property (ACC_DONE && FATAL_FAULT);
   cover property (ACC_DONE && ACC_HIT && ACC_MEM_TYPE == 2'h3);
   cover property (PSLVERR);
endmodule // region_protection_config_checker

bind region_protection_config region_protection_config_checker chk_u (
   .CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .ACC_VALID(ACC_VALID), .ACC_DONE(ACC_DONE), .ACC_HIT(ACC_HIT),
   .ACC_MEM_TYPE(ACC_MEM_TYPE), .ACC_SHAREABLE(ACC_SHAREABLE), .FATAL_FAULT(FATAL_FAULT));
`default_nettype wire

// File: verif/core_access_model.sv
// core load, store and fetch path feeding the protection block
// assumes issue is called just after a rising edge, one access per call
`timescale 1ns/10ps
`default_nettype none
module core_access_model (
   // clock
   input  wire logic        clk,
   // access to the checker
   output var  logic        acc_valid,
   output var  logic [31:0] acc_addr,
   output var  logic        acc_write,
   output var  logic        acc_fetch,
   output var  logic        acc_priv
);
   initial begin
      acc_valid = 1'b0;
      acc_addr = 32'h0;
      acc_write = 1'b0;
      acc_fetch = 1'b0;
      acc_priv = 1'b0;
   end

   // fields are inverted once released so a stale value never passes as held
   task automatic issue(input logic [31:0] a, input logic w, f, p);
      acc_valid <= 1'b1;
      acc_addr <= a;
      acc_write <= w;
      acc_fetch <= f;
      acc_priv <= p;
      @(posedge clk);
      acc_valid <= 1'b0;
      acc_addr <= ~a;
      acc_write <= ~w;
      acc_fetch <= ~f;
      acc_priv <= ~p;
   endtask
endmodule // core_access_model
`default_nettype wire

// File: verif/region_protection_config_tb.sv
// self-checking bench: apb register access and access checking of the protection block
// assumes the design answers apb with one access cycle and verdicts one cycle late
`timescale 1ns/10ps
`default_nettype none
`include "region_protection_cfg.svh"
module region_protection_config_tb;
   logic                  CLK, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
   logic [`ADDR_BITS-1:0] PADDR;
   logic [31:0]           PWDATA, PRDATA, ACC_ADDR, q;
   logic                  ACC_VALID, ACC_WRITE, ACC_FETCH, ACC_PRIV, e;
   logic                  ACC_DONE, ACC_HIT, ACC_SHAREABLE, FATAL_FAULT;
   logic [2:0]            ACC_REGION;
   logic [1:0]            ACC_MEM_TYPE;
   int                    mismatches, n_checks;

   initial CLK = 1'b0;
   always #50 CLK = ~CLK;

   region_protection_config dut_u (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .ACC_VALID(ACC_VALID),
      .ACC_ADDR(ACC_ADDR), .ACC_WRITE(ACC_WRITE), .ACC_FETCH(ACC_FETCH),
      .ACC_PRIV(ACC_PRIV), .ACC_DONE(ACC_DONE), .ACC_HIT(ACC_HIT),
      .ACC_REGION(ACC_REGION), .ACC_MEM_TYPE(ACC_MEM_TYPE),
      .ACC_SHAREABLE(ACC_SHAREABLE), .FATAL_FAULT(FATAL_FAULT));

   core_access_model core_u (.clk(CLK), .acc_valid(ACC_VALID), .acc_addr(ACC_ADDR),
      .acc_write(ACC_WRITE), .acc_fetch(ACC_FETCH), .acc_priv(ACC_PRIV));

   task close_out;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // an idle edge after each transfer keeps psel from being driven twice in one step
   task automatic apb(input logic w, input logic [`ADDR_BITS-1:0] a, input logic [31:0] d,
                      output logic [31:0] rq, output logic re);
      int n;
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      if (n >= 20) begin
         mismatches++;
         close_out;
      end
      rq = PRDATA;
      re = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
   endtask

   task wr(input logic [`ADDR_BITS-1:0] a, input logic [31:0] d);
      apb(1'b1, a, d, q, e);
   endtask

   task rd(input logic [`ADDR_BITS-1:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, q, e);
      chk("register read", exp, q);
   endtask

   task automatic acc(input logic [31:0] a, input logic w, f, p, ef, eh,
                      input logic [2:0] er);
      core_u.issue(a, w, f, p);
      @(negedge CLK);
      chk("verdict", {26'h0, 1'b1, ef, eh, er},
          {26'h0, ACC_DONE, FATAL_FAULT, ACC_HIT, ACC_HIT ? ACC_REGION : 3'h0});
      @(posedge CLK);
   endtask

   task mem(input logic [1:0] et, input logic es);
      chk("memory type", {29'h0, es, et}, {29'h0, ACC_SHAREABLE, ACC_MEM_TYPE});
   endtask

   task t_reset;
      rd(`OFS_SELECT, 32'h0);
      rd(`OFS_ATTR, 32'h0);
      acc(32'h20000000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0);
   endtask

   task t_select;
      wr(`OFS_BASE, 32'h20000015);
      rd(`OFS_SELECT, 32'h5);
      rd(`OFS_BASE, 32'h20000005);
      wr(`OFS_BASE, 32'h40000002);
      rd(`OFS_SELECT, 32'h5);
      rd(`OFS_BASE, 32'h40000005);
      wr(`OFS_ATTR, 32'hffffffff);
      rd(`OFS_ATTR, 32'h1707ff3f);
      rd(`OFS_BASE, 32'h00000005);
      wr(`OFS_BASE, 32'h400000e0);
      wr(`OFS_ATTR, 32'h0000000e);
      rd(`OFS_BASE, 32'h40000005);
      wr(`OFS_SELECT, 32'h0);
      rd(`OFS_ATTR, 32'h0);
   endtask

   task t_regions;
      wr(`OFS_BASE, 32'h20000011);
      wr(`OFS_ATTR, 32'h0306001f);
      wr(`OFS_BASE, 32'h20000012);
      wr(`OFS_ATTR, 32'h1601020f);
      wr(`OFS_CHECK_CTRL, 32'h1);
      acc(32'h20000000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h2);
      mem(2'h1, 1'b1);
      acc(32'h20000000, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 3'h2);
      acc(32'h20000004, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 3'h2);
      acc(32'h20000100, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 3'h1);
      acc(32'h20000020, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 3'h1);
      mem(2'h2, 1'b1);
      acc(32'h30000000, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 3'h0);
      rd(`OFS_FAULT_ADDR, 32'h30000000);
      rd(`OFS_FAULT_STAT, 32'h9);
      wr(`OFS_FAULT_STAT, 32'h1);
      rd(`OFS_FAULT_STAT, 32'h8);
   endtask

   task t_perm;
      logic [3:0] tbl [8];
      tbl = '{4'hf, 4'hc, 4'h8, 4'h0, 4'h0, 4'he, 4'ha, 4'ha};
      wr(`OFS_SELECT, 32'h1);
      for (int c = 0; c < 8; c++) begin
         // code 100 is left unpredictable, so software never programs it
         if (c == 4) continue;
         wr(`OFS_ATTR, {5'h0, c[2:0], 24'h06001f});
         for (int k = 0; k < 4; k++) begin
            acc(32'h20000100, k[0], 1'b0, !k[1], tbl[c][k], 1'b1, 3'h1);
         end
      end
   endtask

   task t_full;
      wr(`OFS_BASE, 32'h00000013);
      wr(`OFS_ATTR, 32'h0303003f);
      acc(32'hf0000000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 3'h3);
      mem(2'h3, 1'b0);
      acc(32'h20000000, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 3'h3);
   endtask

   task t_unmapped;
      apb(1'b1, 8'h1c, 32'hffffffff, q, e);
      chk("slave error", 32'h1, {31'h0, e});
      apb(1'b0, 8'h1c, 32'h0, q, e);
      chk("read error", 32'h1, {31'h0, e});
      chk("unmapped read", 32'h0, q);
   endtask

   // reset in mid-run must drop every programmed region
   task t_rerun;
      RST_B <= 1'b0;
      @(posedge CLK);
      RST_B <= 1'b1;
      @(posedge CLK);
      rd(`OFS_SELECT, 32'h0);
      wr(`OFS_SELECT, 32'h3);
      rd(`OFS_ATTR, 32'h0);
      wr(`OFS_CHECK_CTRL, 32'h1);
      acc(32'h00000000, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 3'h0);
   endtask

   initial begin
      mismatches = 0;
      n_checks = 0;
      RST_B = 1'b0;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = '0;
      PWDATA = 32'h0;
      repeat (3) @(posedge CLK);
      RST_B <= 1'b1;
      @(posedge CLK);
      t_reset;
      t_select;
      t_regions;
      t_perm;
      t_full;
      t_unmapped;
      t_rerun;
      close_out;
   end
endmodule // region_protection_config_tb
`default_nettype wire
